// File: amplitude_keying_ramp.sv
// amplitude keying: manual scale, pin gating and linear auto ramp
// Function
// [RL1] keying exists only in single tone mode
// [RL2] enable clear: block idle, timers stopped
// [RL3] auto select bit picks auto or manual
// [RL4] manual amplitude follows written scale factor
// [RL5] manual without pin gate ignores key pin
// [RL6] manual pin gate: key low forces zero
// [RL7] word: rate 31:16, scale 15:2, step 1:0
// [RL8] step timer ticks every four core clocks
// [RL9] key high: ramp up to maximum per expiry
// [RL10] key low: ramp down to zero per expiry
// [RL11] ramp never exceeds programmed maximum
// [RL12] ramp zero at reset, when off or manual
// [RL13] step code selects 1, 2, 4, 8
// [RL14] 14-bit unsigned amplitude while keying enabled
// [RL15] expiry reloads timer with programmed interval
// [RL16] auto select rising plus update reloads timer
// [RL17] key pin change reloads timer
// [RL18] reload bit: update or profile restarts timer
// [RL19] three profile pins pick one of eight
// [RL20] update rise or profile change transfers words
// [RL21] key and profile pins are synchronised
module amplitude_keying_ramp (
	input  wire logic        i_clk,
	input  wire logic        i_rst,
	input  wire logic        i_single_tone_mode,
	input  wire logic        i_prog_wr,
	input  wire logic [2:0]  i_prog_sel,
	input  wire logic [31:0] i_prog_data,
	input  wire logic        i_amplitude_keying_enable,
	input  wire logic        i_auto_ramp_select,
	input  wire logic        i_manual_pin_gate_enable,
	input  wire logic        i_reload_step_timer_on_update,
	input  wire logic        i_amplitude_key_pin,
	input  wire logic        i_io_update,
	input  wire logic [2:0]  i_profile,
	output logic      [13:0] o_amplitude,
	output logic             o_keying_active,
	output logic      [2:0]  o_active_profile,
	output logic      [31:0] o_active_word
);
	typedef struct packed {
		logic [keying_pkg::NUM_PROFILES-1:0][31:0] prof;
		logic [31:0]                               word;
		logic                                      en;
		logic                                      auto_sel;
		logic                                      gate;
		logic                                      reload_upd;
		logic                                      key_q;
		logic                                      upd_q;
		logic [2:0]                                prof_q;
		logic [1:0]                                div;
		logic [15:0]                               timer;
		logic [13:0]                               ramp;
		keying_pkg::keying_mode_t                  mode;
		logic [13:0]                               amp_out;
		logic                                      active_out;
	} state_t;

	state_t s;
	state_t next_s;

	logic [keying_pkg::SYNC_WIDTH-1:0] pins_s;
	logic                              key_s;
	logic                              upd_s;
	logic [2:0]                        prof_s;
	logic                              upd_rise;
	logic                              prof_chg;
	logic                              xfer;
	logic                              reload;
	logic                              tick;
	logic                              expire;
	logic [15:0]                       rate;
	logic [13:0]                       max_scale;
	logic [13:0]                       step;
	logic [14:0]                       sum;
	logic [31:0]                       sel_word;

	// =========================================================
	// pin synchronisation
	pin_sync #(
		.WIDTH(keying_pkg::SYNC_WIDTH)
	) u_pin_sync (
		.i_clk (i_clk),
		.i_rst (i_rst),
		.i_pins({i_profile, i_io_update, i_amplitude_key_pin}),
		.o_pins(pins_s)
	); // [RL21]

	assign key_s  = pins_s[keying_pkg::SYNC_KEY];
	assign upd_s  = pins_s[keying_pkg::SYNC_UPDATE];
	assign prof_s = pins_s[keying_pkg::SYNC_PROF_LSB +: 3];

	// =========================================================
	// field decode of the active word
	assign rate      = s.word[keying_pkg::RATE_MSB:keying_pkg::RATE_LSB];    // [RL7]
	assign max_scale = s.word[keying_pkg::SCALE_MSB:keying_pkg::SCALE_LSB];  // [RL7]
	assign step      = keying_pkg::STEP_UNIT << s.word[keying_pkg::STEP_MSB:keying_pkg::STEP_LSB]; // [RL13]
	assign sum       = {1'b0, s.ramp} + {1'b0, step};
	assign sel_word  = s.prof[prof_s]; // [RL19]

	// =========================================================
	// update events and timer reload sources
	assign upd_rise = upd_s & ~s.upd_q;
	assign prof_chg = prof_s != s.prof_q;
	assign xfer     = upd_rise | prof_chg; // [RL20]
	assign reload   = (upd_rise & i_auto_ramp_select & ~s.auto_sel) // [RL16]
	                | (key_s != s.key_q)                            // [RL17]
	                | (xfer & s.reload_upd);                        // [RL18]
	assign tick     = s.div == keying_pkg::PRESCALE_LAST; // [RL8]
	assign expire   = (s.mode == keying_pkg::MODE_AUTO) && !reload && tick && (s.timer <= 16'h0001);

	// =========================================================
	// next state
	always_comb begin
		next_s        = s;
		next_s.key_q  = key_s;
		next_s.upd_q  = upd_s;
		next_s.prof_q = prof_s;
		if (i_prog_wr) begin
			next_s.prof[i_prog_sel] = i_prog_data;
		end
		if (xfer) begin
			next_s.word       = sel_word; // [RL20]
			next_s.en         = i_amplitude_keying_enable;
			next_s.auto_sel   = i_auto_ramp_select;
			next_s.gate       = i_manual_pin_gate_enable;
			next_s.reload_upd = i_reload_step_timer_on_update;
		end

		if (!(s.en && i_single_tone_mode)) begin
			next_s.mode = keying_pkg::MODE_OFF; // [RL1] [RL2]
		end else if (s.auto_sel) begin
			next_s.mode = keying_pkg::MODE_AUTO; // [RL3]
		end else begin
			next_s.mode = keying_pkg::MODE_MANUAL; // [RL3]
		end

		case (s.mode)
			keying_pkg::MODE_AUTO: begin
				next_s.div = s.div + 2'h1; // [RL8]
				if (reload) begin
					next_s.timer = rate; // [RL16] [RL17] [RL18]
					next_s.div   = '0;
				end else if (tick) begin
					if (s.timer <= 16'h0001) begin
						next_s.timer = rate; // [RL15]
					end else begin
						next_s.timer = s.timer - 16'h0001; // [RL8]
					end
				end
				if (expire) begin
					if (key_s) begin
						if (sum > {1'b0, max_scale}) begin
							next_s.ramp = max_scale; // [RL9] [RL11]
						end else begin
							next_s.ramp = sum[13:0]; // [RL9]
						end
					end else if (s.ramp > step) begin
						next_s.ramp = s.ramp - step; // [RL10]
					end else begin
						next_s.ramp = '0; // [RL10]
					end
				end
				// a lowered maximum pulls the ramp down at once, even on a down step
				if (next_s.ramp > max_scale) begin
					next_s.ramp = max_scale; // [RL11]
				end
				next_s.amp_out    = next_s.ramp; // [RL14]
				next_s.active_out = 1'b1;
			end
			keying_pkg::MODE_MANUAL: begin
				next_s.div   = '0;
				next_s.timer = rate;
				next_s.ramp  = '0; // [RL12]
				if (s.gate && !key_s) begin
					next_s.amp_out = '0; // [RL6]
				end else begin
					next_s.amp_out = max_scale; // [RL4] [RL5]
				end
				next_s.active_out = 1'b1;
			end
			default: begin
				// stopped: prescaler cleared and timer held at the programmed rate to save power
				next_s.div        = '0; // [RL2]
				next_s.timer      = rate;
				next_s.ramp       = '0; // [RL12]
				next_s.amp_out    = '0;
				next_s.active_out = 1'b0;
			end
		endcase
	end

	// =========================================================
	// state register
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			s      <= '0; // [RL12]
			s.word <= keying_pkg::RAMP_WORD_RESET;
			s.prof <= {keying_pkg::NUM_PROFILES{keying_pkg::RAMP_WORD_RESET}};
		end else begin
			s <= next_s;
		end
	end

	assign o_amplitude      = s.amp_out;
	assign o_keying_active  = s.active_out;
	assign o_active_profile = s.prof_q;
	assign o_active_word    = s.word;

	// =========================================================
	// assertions
	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (i_rst);

	tone_only_a: // [RL1]
	assert property (!i_single_tone_mode |=> s.mode == keying_pkg::MODE_OFF ##1 (o_amplitude == 14'h0000 && !o_keying_active))
	else $error("keying active outside single tone mode");

	off_frozen_a: // [RL2]
	assert property (s.mode == keying_pkg::MODE_OFF |=> s.div == 2'h0 && s.timer == $past(rate))
	else $error("timer runs while keying disabled");

	auto_select_a: // [RL3]
	assert property (s.en && i_single_tone_mode && s.auto_sel |=> s.mode == keying_pkg::MODE_AUTO)
	else $error("auto mode not entered");

	manual_scale_a: // [RL5]
	assert property (s.mode == keying_pkg::MODE_MANUAL && !s.gate |=> o_amplitude == $past(max_scale))
	else $error("manual amplitude not scale factor");

	gate_zero_a: // [RL6]
	assert property (s.mode == keying_pkg::MODE_MANUAL && s.gate && !key_s |=> o_amplitude == 14'h0000)
	else $error("gated manual amplitude not zero");

	prescale_hold_a: // [RL8]
	assert property (s.mode == keying_pkg::MODE_AUTO && !reload && !tick |=> s.timer == $past(s.timer))
	else $error("timer moved between prescale ticks");

	ramp_up_a: // [RL9]
	assert property (expire && key_s && s.ramp < max_scale |=> s.ramp > $past(s.ramp))
	else $error("ramp did not rise on expiry");

	ramp_down_a: // [RL10]
	assert property (expire && !key_s && s.ramp != 14'h0000 |=> s.ramp < $past(s.ramp))
	else $error("ramp did not fall on expiry");

	ramp_clamp_a: // [RL11]
	assert property (s.mode == keying_pkg::MODE_AUTO |=> s.ramp <= $past(max_scale))
	else $error("ramp above maximum scale");

	ramp_idle_a: // [RL12]
	assert property (s.mode != keying_pkg::MODE_AUTO |=> s.ramp == 14'h0000)
	else $error("ramp not zero outside auto mode");

	key_reload_a: // [RL17]
	assert property (s.mode == keying_pkg::MODE_AUTO && key_s != s.key_q |=> s.timer == $past(rate) && s.div == 2'h0)
	else $error("key change did not reload timer");

	word_xfer_a: // [RL20]
	assert property (xfer |=> s.word == $past(sel_word))
	else $error("profile word not transferred");

	mode_off_a: // [RL2]
	assert property (
		!s.en
		|=> s.mode == keying_pkg::MODE_OFF)
	else $error("keying not off while disabled");

	off_output_a: // [RL2]
	assert property (
		s.mode == keying_pkg::MODE_OFF
		|=> o_amplitude == 14'h0000 && !o_keying_active)
	else $error("outputs not idle while off");

	manual_select_a: // [RL3]
	assert property (
		s.en && i_single_tone_mode && !s.auto_sel
		|=> s.mode == keying_pkg::MODE_MANUAL)
	else $error("manual mode not entered");

	manual_follow_a: // [RL4]
	assert property (
		s.mode == keying_pkg::MODE_MANUAL && (!s.gate || key_s)
		|=> o_amplitude == $past(max_scale))
	else $error("manual amplitude does not follow scale");

	gate_pass_a: // [RL6]
	assert property (
		s.mode == keying_pkg::MODE_MANUAL && s.gate && key_s
		|=> o_amplitude == $past(max_scale))
	else $error("gated amplitude not scale with key high");

	prescale_count_a: // [RL8]
	assert property (
		s.mode == keying_pkg::MODE_AUTO && !reload
		|=> s.div == $past(s.div) + 2'h1)
	else $error("prescaler did not advance");

	timer_count_a: // [RL8]
	assert property (
		s.mode == keying_pkg::MODE_AUTO && !reload && tick && s.timer > 16'h0001
		|=> s.timer == $past(s.timer) - 16'h0001)
	else $error("timer did not count down on tick");

	floor_zero_a: // [RL10]
	assert property (
		expire && !key_s && s.ramp <= step
		|=> s.ramp == 14'h0000)
	else $error("ramp did not stop at zero");

	step_up_a: // [RL13]
	assert property (
		expire && key_s && sum <= {1'b0, max_scale}
		|=> s.ramp == $past(s.ramp) + $past(step))
	else $error("ramp step size wrong");

	auto_output_a: // [RL14]
	assert property (
		s.mode == keying_pkg::MODE_AUTO
		|=> o_amplitude == s.ramp)
	else $error("amplitude does not show ramp");

	active_flag_a: // [RL14]
	assert property (
		s.mode != keying_pkg::MODE_OFF
		|=> o_keying_active)
	else $error("active flag low while keying");

	expiry_reload_a: // [RL15]
	assert property (
		expire
		|=> s.timer == $past(rate) && s.div == 2'h0)
	else $error("timer not reloaded on expiry");

	auto_entry_a: // [RL16]
	assert property (
		s.mode != keying_pkg::MODE_AUTO
		|=> s.div == 2'h0 && s.timer == $past(rate))
	else $error("timer not fresh before auto mode");

	update_reload_a: // [RL18]
	assert property (
		s.mode == keying_pkg::MODE_AUTO && xfer && s.reload_upd
		|=> s.timer == $past(rate) && s.div == 2'h0)
	else $error("transfer did not restart timer");

	word_hold_a: // [RL20]
	assert property (
		!xfer
		|=> s.word == $past(s.word))
	else $error("active word changed without transfer");
endmodule : amplitude_keying_ramp

// File: keying_pkg.sv
// constants and types shared by the amplitude keying ramp block
package keying_pkg;
	// programmed word layout
	localparam int          RATE_MSB        = 31;
	localparam int          RATE_LSB        = 16;
	localparam int          SCALE_MSB       = 15;
	localparam int          SCALE_LSB       = 2;
	localparam int          STEP_MSB        = 1;
	localparam int          STEP_LSB        = 0;
	localparam logic [31:0] RAMP_WORD_RESET = 32'h0000_0000;
	// timer prescale: one tick every four core clocks
	localparam int          CLK_PERIOD_NS   = 4;
	localparam int          PRESCALE        = 4;
	localparam logic [1:0]  PRESCALE_LAST   = 2'(PRESCALE - 1);
	localparam int          NUM_PROFILES    = 8;
	// sync pin vector positions
	localparam int          SYNC_WIDTH      = 5;
	localparam int          SYNC_KEY        = 0;
	localparam int          SYNC_UPDATE     = 1;
	localparam int          SYNC_PROF_LSB   = 2;
	localparam logic [13:0] STEP_UNIT       = 14'h0001;

	typedef enum logic [1:0] {
		MODE_OFF    = 2'b00,
		MODE_MANUAL = 2'b01,
		MODE_AUTO   = 2'b11
	} keying_mode_t;
endpackage : keying_pkg

// File: pin_controller.sv
// controller model driving the key, profile and update pins
module pin_controller (
	input  wire logic       i_clk,
	input  wire logic       i_key,
	input  wire logic [2:0] i_profile,
	input  wire logic       i_update_req,
	output logic            o_key,
	output logic      [2:0] o_profile,
	output logic            o_io_update
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [1:0] cnt = 2'h0;
	// pins change only after the falling edge; update held high three cycles
	always @(negedge i_clk) begin
		o_key <= i_key;
		o_profile <= i_profile;
		if (i_update_req) begin
			cnt <= 2'h3;
		end else if (cnt != 2'h0) begin
			cnt <= cnt - 2'h1;
		end
		o_io_update <= (cnt != 2'h0);
	end
endmodule : pin_controller

// File: pin_sync.sv
// two-stage synchroniser for the key, update and profile pins
module pin_sync #(
	parameter int WIDTH = 5
) (
	input  wire logic             i_clk,
	input  wire logic             i_rst,
	input  wire logic [WIDTH-1:0] i_pins,
	output logic      [WIDTH-1:0] o_pins
);
	typedef struct packed {
		logic [WIDTH-1:0] first;
		logic [WIDTH-1:0] second;
	} sync_t;

	sync_t s;
	sync_t next_s;

	always_comb begin
		next_s        = s;
		next_s.first  = i_pins;
		next_s.second = s.first;
	end

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign o_pins = s.second;
endmodule : pin_sync

// File: tb_amplitude_keying_ramp.sv
// self-checking testbench for the amplitude keying ramp block
module tb_amplitude_keying_ramp;
	timeunit 1ns;
	timeprecision 1ps;
	logic        i_clk = 1'b0, i_rst = 1'b1, tone = 1'b1, wr = 1'b0, en = 1'b0, auto_sel = 1'b0;
	logic        gate = 1'b0, key_cmd = 1'b0, upd_req = 1'b0, reload_upd = 1'b0;
	logic [2:0]  sel = 3'h0, prof_cmd = 3'h0;
	logic [31:0] data = 32'h0000_0000;
	wire logic        key, upd, act;
	wire logic [2:0]  prof, aprof;
	wire logic [13:0] amp;
	wire logic [31:0] aword;
	int          n_errors = 0, checks = 0, cyc = 0, n;
	logic [13:0] a;
	initial begin
		forever #2 i_clk = ~i_clk;
	end
	pin_controller ctl (.i_clk(i_clk), .i_key(key_cmd), .i_profile(prof_cmd), .i_update_req(upd_req),
		.o_key(key), .o_profile(prof), .o_io_update(upd));
	amplitude_keying_ramp dut (.i_clk(i_clk), .i_rst(i_rst), .i_single_tone_mode(tone), .i_prog_wr(wr),
		.i_prog_sel(sel), .i_prog_data(data), .i_amplitude_keying_enable(en), .i_auto_ramp_select(auto_sel),
		.i_manual_pin_gate_enable(gate), .i_reload_step_timer_on_update(reload_upd), .i_amplitude_key_pin(key),
		.i_io_update(upd), .i_profile(prof), .o_amplitude(amp), .o_keying_active(act),
		.o_active_profile(aprof), .o_active_word(aword));
	// ==========================================
	// tasks
	task end_of_test();
		$display("errors %0d checks %0d", n_errors, checks);
		if (n_errors == 0 && checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : end_of_test
	task chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
		checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("ERROR %0t %s seen %h expected %h", $time, msg, seen, exp);
		end
	endtask : chk
	task prog(input logic [2:0] s, input logic [31:0] d);
		@(negedge i_clk);
		wr = 1'b1;
		sel = s;
		data = d;
		@(negedge i_clk);
		wr = 1'b0;
	endtask : prog
	task update(input logic e, input logic au, input logic g);
		@(negedge i_clk);
		en = e;
		auto_sel = au;
		gate = g;
		upd_req <= 1'b1;
		@(negedge i_clk);
		upd_req <= 1'b0;
		repeat (10) @(negedge i_clk);
	endtask : update
	task wait_chg();
		a = amp;
		n = 0;
		do begin
			@(negedge i_clk);
			n++;
		end while (amp === a && n < 100);
	endtask : wait_chg
	// ==========================================
	// timeout
	always @(posedge i_clk) begin
		cyc++;
		if (cyc == 3000) begin
			n_errors++;
			end_of_test();
		end
	end
	// ==========================================
	// scenarios
	initial begin
		repeat (5) @(negedge i_clk);
		i_rst = 1'b0;
		chk(32'(amp), 32'h0000_0000, "amp at reset");
		chk(aword, 32'h0000_0000, "word at reset");
		prog(3'h0, 32'h0001_0015);
		update(1'b1, 1'b0, 1'b0);
		chk(aword, 32'h0001_0015, "active word");
		chk(32'(amp), 32'h0000_0005, "manual scale");
		chk(32'(act), 32'h0000_0001, "keying active");
		key_cmd <= 1'b1;
		repeat (10) @(negedge i_clk);
		chk(32'(amp), 32'h0000_0005, "key ignored");
		update(1'b1, 1'b0, 1'b1);
		key_cmd <= 1'b0;
		repeat (8) @(negedge i_clk);
		chk(32'(amp), 32'h0000_0000, "gate key low");
		key_cmd <= 1'b1;
		repeat (8) @(negedge i_clk);
		chk(32'(amp), 32'h0000_0005, "gate key high");
		for (int c = 0; c < 4; c++) begin
			prog(3'h0, {16'h0003, 14'h3fff, 2'(c)});
			update(1'b1, 1'b1, 1'b0);
			repeat (20) @(negedge i_clk);
			wait_chg();
			wait_chg();
			chk(32'(14'(amp - a)), 32'h0000_0001 << c, "step size");
			chk(32'(n), 32'h0000_000c, "step interval");
		end
		prog(3'h0, 32'h0001_0015);
		update(1'b1, 1'b1, 1'b0);
		repeat (40) @(negedge i_clk);
		chk(32'(amp), 32'h0000_0005, "clamp to max");
		key_cmd <= 1'b0;
		repeat (40) @(negedge i_clk);
		chk(32'(amp), 32'h0000_0000, "ramp down");
		key_cmd <= 1'b1;
		repeat (40) @(negedge i_clk);
		chk(32'(amp), 32'h0000_0005, "ramp up");
		// updates every 12 cycles keep restarting a 16-cycle step timer
		prog(3'h0, {16'h0004, 14'h3fff, 2'h0});
		reload_upd = 1'b1;
		update(1'b1, 1'b1, 1'b0);
		update(1'b1, 1'b1, 1'b0);
		a = amp;
		repeat (3) update(1'b1, 1'b1, 1'b0);
		chk(32'(amp), 32'(a), "timer restarted by update");
		repeat (20) @(negedge i_clk);
		chk(32'(amp), 32'(a + 14'h0001), "ramp resumes");
		prog(3'h3, 32'h0002_0028);
		prof_cmd <= 3'h3;
		repeat (10) @(negedge i_clk);
		chk(32'(aprof), 32'h0000_0003, "profile pins");
		chk(aword, 32'h0002_0028, "profile word");
		update(1'b0, 1'b0, 1'b0);
		chk(32'(amp), 32'h0000_0000, "disabled amp");
		chk(32'(act), 32'h0000_0000, "disabled flag");
		update(1'b1, 1'b0, 1'b0);
		tone = 1'b0;
		repeat (4) @(negedge i_clk);
		chk(32'(act), 32'h0000_0000, "not single tone");
		chk(32'(amp), 32'h0000_0000, "not single tone amp");
		end_of_test();
	end
endmodule : tb_amplitude_keying_ramp
